// *** spi_slave_mode_control_bench.sv ***
`timescale 1ns/100ps
module spi_slave_mode_control_bench
  import spimc_pkg::*;
;
  // arbitrary identification values
  localparam logic [15:0] ID_E [5] = '{16'h3C00, 16'h0200, 16'h5A00,
    16'h6B00, FRAME_ID_VAL};
  localparam logic [5:0]  ID_A [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3E};
  logic                             pclk, presetn, psel, penable, pwrite;
  logic                             pready, pslverr, shut_in, warn_in, sl;
  logic                             an1, de1, an2, de2;
  logic [11:0]                      paddr;
  logic [31:0]                      pwdata, prdata;
  logic [N_STAT-1:0][DATA_BITS-1:0] ev;
  logic [N_CTRL-1:0][DATA_BITS-1:0] c1, c2;
  logic [DATA_BITS-1:0]             m [N_CTRL];
  logic [23:0]                      r;
  logic [31:0]                      s;
  logic [15:0]                      d;
  int                               err_total, samples_checked, n;

  spimc_if link1 ();
  spimc_if link2 ();

  spimc_host spimc_host_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link1));
  spimc_device #(.ID_HDR(ID_E[0][15:8]), .ID_VER(ID_E[1][15:8]),
    .ID_CODE1(ID_E[2][15:8]), .ID_CODE2(ID_E[3][15:8])) spimc_device_inst (
    .pclk(pclk), .presetn(presetn), .link(link1), .status_events(ev),
    .thermal_shutdown_flag_in(shut_in), .thermal_warning_flag_in(warn_in),
    .control_regs(c1), .analog_on(an1), .drivers_enable(de1));
  spimc_device spimc_device_inst2 (.pclk(pclk), .presetn(presetn),
    .link(link2), .status_events(ev), .thermal_shutdown_flag_in(shut_in),
    .thermal_warning_flag_in(warn_in), .control_regs(c2), .analog_on(an2),
    .drivers_enable(de2));
  spimc_properties spimc_properties_inst (.pclk(pclk), .presetn(presetn),
    .chip_select_n(link1.chip_select_n), .sclk(link1.sclk),
    .mosi(link1.mosi), .miso(link1.miso), .miso_oe_n(link1.miso_oe_n));

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic xfer(input logic [24:0] f);
    logic [31:0] q;
    apb(1'b1, HREG_TX, {7'h00, f}, q);
    do begin
      apb(1'b0, HREG_STAT, 32'h00000000, q);
    end while (q[HST_BUSY_BIT] !== 1'b0);
    s = q;
    apb(1'b0, HREG_RX, 32'h00000000, q);
    r = q[23:0];
  endtask : xfer

  task automatic bang(input int nclk, input logic [23:0] f);
    logic [23:0] sh;
    sh = f;
    r = 24'h000000;
    @(posedge pclk);
    link2.chip_select_n <= 1'b0;
    link2.mosi <= sh[23];
    for (int i = 0; i < nclk; i++) begin
      repeat (SCK_HALF_CYC) @(posedge pclk);
      link2.sclk <= 1'b1;
      r = {r[22:0], link2.miso};
      sh = sh << 1;
      repeat (SCK_HALF_CYC) @(posedge pclk);
      link2.sclk <= 1'b0;
      link2.mosi <= sh[23];
    end
    repeat (SCK_HALF_CYC) @(posedge pclk);
    link2.chip_select_n <= 1'b1;
    repeat (4 * SCK_HALF_CYC) @(posedge pclk);
  endtask : bang

  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ****************************************************
  // clock, watchdog, tests
  // ****************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, shut_in, warn_in} = '0;
    link2.chip_select_n = 1'b1;
    link2.sclk = 1'b0;
    link2.mosi = 1'b0;
    err_total = 0;
    samples_checked = 0;
    presetn = 1'b0;
    void'($urandom(51));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({an1, de1, |c1}), 32'h0);
    bang(0, 24'h000000);
    chk(32'(an2), 32'h1);
    repeat (WAKE_CYC) @(posedge pclk);
    bang(24, 24'h000001);
    chk(r, 24'h800000);
    bang(23, 24'h01BEEF);
    chk(c2[1], 32'h0);
    bang(24, 24'h410000);
    chk(r, 24'hE00000);
    bang(0, 24'h000000);
    bang(24, 24'h410000);
    chk(r, 24'h200000);
    bang(24, 24'hFFFFFF);
    chk(32'({an2, |c2}), 32'h0);
    xfer(25'h1000000);
    chk(32'(an1), 32'h1);
    chk(32'(s[HST_FAULT_BIT]), 32'h1);
    n = 0;
    while (an1 !== 1'b0 && n < WAKE_CYC + FALLBACK_CYC + 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'({an1, |c1}), 32'h0);
    xfer(25'h1000000);
    xfer({3'b000, 6'h00, 16'h0001});
    chk(r, 24'h800000);
    chk(32'({an1, de1}), 32'h3);
    m = '{default: 16'h0000};
    m[0] = 16'h0001;
    for (int p = 0; p < 2; p++)
      for (int k = 1; k < N_CTRL; k++) begin
        d = 16'($urandom);
        xfer({3'b000, CTRL_ADDR[k], d});
        chk(r[15:0], m[k]);
        m[k] = d;
        chk(c1[k], m[k]);
      end
    for (int k = 0; k < N_CTRL; k++) begin
      xfer({3'b001, CTRL_ADDR[k], 16'h0000});
      chk(r, {8'h20, m[k]});
    end
    d = 16'($urandom) | 16'h0001;
    ev[1] <= d;
    @(posedge pclk);
    ev[1] <= 16'h0000;
    xfer({3'b010, STAT_ADDR[1], 16'h0000});
    chk(r[15:0], d);
    xfer({3'b001, STAT_ADDR[1], 16'h0000});
    chk(r, 24'h200000);
    for (int k = 0; k < 5; k++) begin
      xfer({3'b011, ID_A[k], 16'h0000});
      chk(r[15:0], ID_E[k]);
    end
    warn_in <= 1'b1;
    xfer({3'b001, 6'h00, 16'h0000});
    chk(r[23:16], {~m[CFG_REG][CFG_MASK_WARN], 7'h28});
    warn_in <= 1'b0;
    shut_in <= 1'b1;
    @(posedge pclk);
    shut_in <= 1'b0;
    xfer({3'b001, 6'h00, 16'h0000});
    chk(r[23:16], 8'hB0);
    chk(32'(de1), 32'h0);
    apb(1'b1, HREG_RX, 32'h00000000, s);
    chk(32'(sl), 32'h1);
    xfer(25'h0FFFFFF);
    chk(32'({an1, |c1}), 32'h0);
    summarize();
  end
endmodule : spi_slave_mode_control_bench

// *** spimc_device.sv ***
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
// How it works
// [RULE1] power-up: standby, registers cleared, outputs off
// [RULE2] chip select low in standby wakes device
// [RULE3] host waits 10 us before real frames
// [RULE4] mode bit zero: back to standby, 8 us
// [RULE5] slave only, sample input on clock rise
// [RULE6] output line released while select high
// [RULE7] fault flag on output at select fall
// [RULE8] first clock rise loads output shifter
// [RULE9] frame is 8-bit header plus 16 data
// [RULE10] id reads return 8 bits in MSBs
// [RULE11] frames travel most significant bit first
// [RULE12] output frame: status byte then response
// [RULE13] write returns old register content
// [RULE14] chip select rise ends the transfer
// [RULE15] later output bits change on clock fall
// [RULE16] host clocks only inside frame
// [RULE17] wrong clock count: discard, set error
// [RULE18] all-ones frame forces standby, drivers off
// [RULE19] opcode bits 23:22, address bits 21:16
// [RULE20] opcodes: write, read, read-clear, read id
// [RULE21] read-and-clear returns then clears status
// [RULE22] status byte layout, reset fault, not-ready
// [RULE23] error only for counts not 0, 24
// [RULE24] commit writes only at select rise
module spimc_device
  import spimc_pkg::*;
#(
  // arbitrary identification values
  parameter logic [7:0] ID_HDR   = 8'hA5,
  parameter logic [7:0] ID_VER   = 8'h01,
  parameter logic [7:0] ID_CODE1 = 8'h11,
  parameter logic [7:0] ID_CODE2 = 8'h22
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // serial link
  spimc_if.dev                              link,
  // fault sources
  input  wire logic [N_STAT-1:0][DATA_BITS-1:0] status_events,
  input  wire logic                         thermal_shutdown_flag_in,
  input  wire logic                         thermal_warning_flag_in,
  // device state
  output logic [N_CTRL-1:0][DATA_BITS-1:0]  control_regs,
  output logic                              analog_on,
  output logic                              drivers_enable
);

  typedef enum logic {
    ST_STANDBY = 1'b0,
    ST_ACTIVE  = 1'b1
  } spimc_state_t;

  // ****************************************************
  // edge detection
  // ****************************************************
  spimc_state_t                 state;
  logic                         csn_q;
  logic                         sclk_q;
  logic [FRAME_BITS-1:0]        rx;
  logic [FRAME_BITS-1:0]        out_word;
  logic [CNT_W-1:0]             rcnt;
  logic [TMR_W-1:0]             wake_cnt;
  logic [TMR_W-1:0]             fb_cnt;
  logic [N_STAT-1:0][DATA_BITS-1:0] stat_regs;
  logic                         frame_error_flag;
  logic                         reset_not_flag;
  logic                         thermal_shutdown_flag;

  wire cs_fall  = csn_q & ~link.chip_select_n;
  wire cs_rise  = ~csn_q & link.chip_select_n;             // RULE14
  wire sck_rise = ~link.chip_select_n & ~sclk_q & link.sclk; // RULE5
  wire sck_fall = ~link.chip_select_n & sclk_q & ~link.sclk; // RULE15

  // ****************************************************
  // global status byte
  // ****************************************************
  wire not_ready_flag = (state == ST_STANDBY) || (wake_cnt != '0);
  wire uov_flag = (|stat_regs[0]) | (|stat_regs[2]);
  wire uld_flag = |stat_regs[1];
  wire warn_vis = thermal_warning_flag_in &
                  ~control_regs[CFG_REG][CFG_MASK_WARN];
  wire uld_vis  = uld_flag & ~control_regs[CFG_REG][CFG_MASK_ULD];
  wire global_fault_flag = ~reset_not_flag | frame_error_flag |
                           thermal_shutdown_flag | warn_vis |
                           uov_flag | uld_vis;
  wire [7:0] status_byte = {global_fault_flag, frame_error_flag,
                            reset_not_flag, thermal_shutdown_flag,
                            thermal_warning_flag_in, uov_flag,
                            uld_flag, not_ready_flag}; // RULE22

  // ****************************************************
  // address decode
  // ****************************************************
  wire [7:0]      early_cmd = {rx[6:0], link.mosi};
  wire spimc_op_t early_op  = spimc_op_t'(early_cmd[7:6]);    // RULE19
  wire [5:0]      early_adr = early_cmd[5:0];
  wire spimc_op_t c_op      = spimc_op_t'(rx[23:22]);         // RULE19
  wire [5:0]      c_adr     = rx[21:16];
  wire [DATA_BITS-1:0] c_data = rx[DATA_BITS-1:0];             // RULE9

  logic [N_CTRL-1:0] e_hit_c;
  logic [N_CTRL-1:0] c_hit_c;
  logic [N_STAT-1:0] e_hit_s;
  logic [N_STAT-1:0] c_hit_s;

  genvar gi;
  generate
    for (gi = 0; gi < N_CTRL; gi++) begin : g_ctrl_hit
      assign e_hit_c[gi] = (early_adr == CTRL_ADDR[gi]);
      assign c_hit_c[gi] = (c_adr == CTRL_ADDR[gi]);
    end
    for (gi = 0; gi < N_STAT; gi++) begin : g_stat_hit
      assign e_hit_s[gi] = (early_adr == STAT_ADDR[gi]);
      assign c_hit_s[gi] = (c_adr == STAT_ADDR[gi]);
    end
  endgenerate

  // ****************************************************
  // in-frame response
  // ****************************************************
  logic [DATA_BITS-1:0] reg_rd;
  always_comb begin
    reg_rd = '0;
    for (int i = 0; i < N_CTRL; i++) begin
      if (e_hit_c[i]) reg_rd = reg_rd | control_regs[i]; // RULE13
    end
    for (int i = 0; i < N_STAT; i++) begin
      if (e_hit_s[i]) reg_rd = reg_rd | stat_regs[i];
    end
  end

  wire [7:0] id_byte =
    (early_adr == ID_HDR_ADDR)   ? ID_HDR   :
    (early_adr == ID_VER_ADDR)   ? ID_VER   :
    (early_adr == ID_CODE1_ADDR) ? ID_CODE1 :
    (early_adr == ID_CODE2_ADDR) ? ID_CODE2 :
    (early_adr == ID_FRAME_ADDR) ? FRAME_ID_VAL[15:8] : 8'h00;
  wire [DATA_BITS-1:0] resp = (early_op == OP_READ_ID) ?
                              {id_byte, 8'h00} : reg_rd; // RULE10 RULE20

  // ****************************************************
  // frame check and commit
  // ****************************************************
  wire [CNT_W-1:0] full_cnt = CNT_W'(FRAME_BITS);
  wire frame_full = cs_rise && (rcnt == full_cnt);
  wire stuck      = frame_full && (&rx);                       // RULE18
  wire frame_bad  = cs_rise && (rcnt != '0) &&
                    (rcnt != full_cnt);                  // RULE17 RULE23
  wire commit     = frame_full && !stuck &&
                    (state == ST_ACTIVE);                      // RULE24
  wire do_write   = commit && (c_op == OP_WRITE);
  wire do_clear   = commit && (c_op == OP_RDCLR);              // RULE21
  wire mode_on    = control_regs[MODE_REG][MODE_BIT];
  wire fb_expire  = (state == ST_ACTIVE) && (wake_cnt == '0) &&
                    !mode_on && link.chip_select_n &&
                    (fb_cnt == TMR_W'(FALLBACK_CYC - 1));        // RULE4
  wire go_standby = stuck || fb_expire;
  wire mode_clr   = do_write && c_hit_c[MODE_REG] && !c_data[MODE_BIT];
  wire [CNT_W-1:0] out_idx = CNT_W'(FRAME_BITS - 1) - rcnt;

  spimc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (cs_fall) next_state = ST_ACTIVE;                   // RULE2
      end
      ST_ACTIVE: begin
        if (go_standby) next_state = ST_STANDBY;         // RULE4 RULE18
      end
      default: next_state = ST_STANDBY;
    endcase
  end

  // ****************************************************
  // mode and timers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= ST_STANDBY;                            // RULE1
      wake_cnt       <= '0;
      fb_cnt         <= '0;
      analog_on      <= 1'b0;
      drivers_enable <= 1'b0;
    end else begin
      state     <= next_state;
      analog_on <= (next_state == ST_ACTIVE);
      drivers_enable <= (next_state == ST_ACTIVE) && mode_on &&
                        !go_standby && reset_not_flag &&
                        !thermal_shutdown_flag;                // RULE18
      if (state == ST_STANDBY && cs_fall)
        wake_cnt <= TMR_W'(WAKE_CYC);
      else if (wake_cnt != '0)
        wake_cnt <= wake_cnt - 1'b1;
      if (state == ST_ACTIVE && wake_cnt == '0 && !mode_on &&
          link.chip_select_n && !fb_expire)
        fb_cnt <= fb_cnt + 1'b1;
      else
        fb_cnt <= '0;
    end
  end

  // ****************************************************
  // serial shifter
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csn_q          <= 1'b1;
      sclk_q         <= 1'b0;
      rx             <= '0;
      rcnt           <= '0;
      out_word       <= '0;
      link.miso      <= 1'b0;
      link.miso_oe_n <= 1'b1;
    end else begin
      csn_q          <= link.chip_select_n;
      sclk_q         <= link.sclk;
      link.miso_oe_n <= link.chip_select_n;                    // RULE6
      if (cs_fall) begin
        rcnt <= '0;
      end else if (sck_rise) begin
        rx <= {rx[FRAME_BITS-2:0], link.mosi};           // RULE5 RULE11
        if (rcnt != '1) rcnt <= rcnt + 1'b1;
        if (rcnt == '0) out_word[FRAME_BITS-1 -: 8] <= status_byte; // RULE8
        if (rcnt == CNT_W'(7)) out_word[DATA_BITS-1:0] <= resp; // RULE12
      end
      if (!link.chip_select_n && (cs_fall || rcnt == '0))
        link.miso <= global_fault_flag;                        // RULE7
      else if (sck_fall)
        link.miso <= (rcnt < full_cnt) ? out_word[out_idx] : 1'b0; // RULE15
      else if (link.chip_select_n)
        link.miso <= 1'b0;
    end
  end

  // ****************************************************
  // register file and flags
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_regs          <= '0;                             // RULE1
      stat_regs             <= '0;
      frame_error_flag      <= 1'b0;
      reset_not_flag        <= 1'b0;
      thermal_shutdown_flag <= 1'b0;
    end else begin
      for (int i = 0; i < N_CTRL; i++) begin
        if (go_standby) control_regs[i] <= '0;                 // RULE4
        else if (do_write && c_hit_c[i]) control_regs[i] <= c_data;
      end
      for (int i = 0; i < N_STAT; i++) begin
        if (go_standby) stat_regs[i] <= '0;
        else if (do_clear && c_hit_s[i])
          stat_regs[i] <= status_events[i];                    // RULE21
        else
          stat_regs[i] <= stat_regs[i] | status_events[i];
      end
      if (frame_bad) frame_error_flag <= 1'b1;                 // RULE17
      else if (frame_full) frame_error_flag <= 1'b0;
      if (stuck) reset_not_flag <= 1'b0;                       // RULE18
      else if (do_write) reset_not_flag <= 1'b1;
      if (thermal_shutdown_flag_in) thermal_shutdown_flag <= 1'b1;
      else if (mode_clr) thermal_shutdown_flag <= 1'b0;
    end
  end

endmodule : spimc_device

// *** spimc_host.sv ***
`timescale 1ns/100ps
module spimc_host
  import spimc_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  spimc_if.host            link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_HIGH = 3'b010,
    H_LOW  = 3'b011,
    H_TAIL = 3'b100,
    H_GAP  = 3'b101
  } spimc_hstate_t;

  // ****************************************************
  // apb decode
  // ****************************************************
  spimc_hstate_t         hstate;
  logic [FRAME_BITS-1:0] tx;
  logic [FRAME_BITS-1:0] rx;
  logic [CNT_W-1:0]      bcnt;
  logic [TMR_W-1:0]      tmr;
  logic                  poll;
  logic                  poll_fault;

  wire busy     = (hstate != H_IDLE);
  wire setup    = psel && !penable;
  wire take     = psel && penable && pready;
  wire hit_tx   = (paddr == HREG_TX);
  wire hit_rx   = (paddr == HREG_RX);
  wire hit_st   = (paddr == HREG_STAT);
  wire mapped   = hit_tx || (!pwrite && (hit_rx || hit_st));
  wire start    = take && pwrite && hit_tx && !busy;
  wire tick     = (tmr == '0);
  wire [CNT_W-1:0] full_cnt = CNT_W'(FRAME_BITS);
  wire [CNT_W-1:0] tx_idx   = CNT_W'(FRAME_BITS - 1) - bcnt;
  wire [TMR_W-1:0] half     = TMR_W'(SCK_HALF - 1);
  wire [31:0] rd_val =
    hit_rx ? {8'h00, rx} :
    hit_st ? {30'h0, poll_fault, busy} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup ? rd_val : 32'h0;
    end
  end

  // ****************************************************
  // frame sequencer
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate             <= H_IDLE;
      tx                 <= '0;
      rx                 <= '0;
      bcnt               <= '0;
      tmr                <= '0;
      poll               <= 1'b0;
      poll_fault         <= 1'b0;
      link.chip_select_n <= 1'b1;
      link.sclk          <= 1'b0;
      link.mosi          <= 1'b0;
    end else begin
      if (!tick) tmr <= tmr - 1'b1;
      case (hstate)
        H_IDLE: begin
          if (start) begin
            tx                 <= pwdata[FRAME_BITS-1:0];
            poll               <= pwdata[TX_POLL_BIT];
            link.chip_select_n <= 1'b0;
            link.mosi          <= pwdata[FRAME_BITS-1];     // RULE11
            bcnt               <= '0;
            tmr                <= half;
            hstate             <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (tick && poll) begin
            tmr    <= half;
            hstate <= H_TAIL;
          end else if (tick) begin
            link.sclk <= 1'b1;                              // RULE16
            rx        <= {rx[FRAME_BITS-2:0], link.miso};
            bcnt      <= bcnt + 1'b1;
            tmr       <= half;
            hstate    <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            link.sclk <= 1'b0;
            tmr       <= half;
            if (bcnt == full_cnt) begin                     // RULE9
              hstate <= H_TAIL;
            end else begin
              link.mosi <= tx[tx_idx];
              hstate    <= H_LOW;
            end
          end
        end
        H_LOW: begin
          if (tick) begin
            link.sclk <= 1'b1;
            rx        <= {rx[FRAME_BITS-2:0], link.miso};
            bcnt      <= bcnt + 1'b1;
            tmr       <= half;
            hstate    <= H_HIGH;
          end
        end
        H_TAIL: begin
          if (tick) begin
            if (poll) poll_fault <= link.miso;
            link.chip_select_n <= 1'b1;
            link.mosi          <= 1'b0;
            tmr    <= poll ? TMR_W'(WAKE_CYC) : half;       // RULE3
            hstate <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) hstate <= H_IDLE;
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end

endmodule : spimc_host

// *** spimc_if.sv ***
`timescale 1ns/100ps
interface spimc_if;
  logic chip_select_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;

  modport host (
    output chip_select_n,
    output sclk,
    output mosi,
    input  miso,
    input  miso_oe_n
  );

  modport dev (
    input  chip_select_n,
    input  sclk,
    input  mosi,
    output miso,
    output miso_oe_n
  );
endinterface : spimc_if

// *** spimc_pkg.sv ***
package spimc_pkg;
  // ****************************************************
  // frame layout
  // ****************************************************
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 16;
  localparam int CNT_W      = 5;
  localparam int TMR_W      = 12;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_WAKE_NS     = 10000;
  localparam int T_FALLBACK_NS = 8000;
  localparam int WAKE_CYC      =
    (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FALLBACK_CYC  = T_FALLBACK_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC  = 4;

  // ****************************************************
  // command byte
  // ****************************************************
  typedef enum logic [1:0] {
    OP_WRITE   = 2'b00,
    OP_READ    = 2'b01,
    OP_RDCLR   = 2'b10,
    OP_READ_ID = 2'b11
  } spimc_op_t;

  // ****************************************************
  // device register map
  // ****************************************************
  localparam int N_CTRL = 7;
  localparam int N_STAT = 3;
  localparam logic [5:0] CTRL_ADDR [N_CTRL] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h3F};
  localparam logic [5:0] STAT_ADDR [N_STAT] = '{6'h10, 6'h11, 6'h12};
  localparam logic [5:0] ID_HDR_ADDR   = 6'h00;
  localparam logic [5:0] ID_VER_ADDR   = 6'h01;
  localparam logic [5:0] ID_CODE1_ADDR = 6'h02;
  localparam logic [5:0] ID_CODE2_ADDR = 6'h03;
  localparam logic [5:0] ID_FRAME_ADDR = 6'h3E;
  localparam logic [15:0] FRAME_ID_VAL = 16'h0200;
  localparam int MODE_REG     = 0;
  localparam int MODE_BIT     = 0;
  localparam int CFG_REG      = 6;
  localparam int CFG_MASK_WARN = 0;
  localparam int CFG_MASK_ULD = 1;

  // ****************************************************
  // global status byte
  // ****************************************************
  localparam int ST_FAULT     = 7;
  localparam int ST_FRAME_ERR = 6;
  localparam int ST_RESN      = 5;
  localparam int ST_SHUTDOWN  = 4;
  localparam int ST_WARN      = 3;
  localparam int ST_UOV       = 2;
  localparam int ST_ULD       = 1;
  localparam int ST_NOT_READY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h81;

  // ****************************************************
  // host apb map
  // ****************************************************
  localparam logic [11:0] HREG_TX   = 12'h000;
  localparam logic [11:0] HREG_RX   = 12'h004;
  localparam logic [11:0] HREG_STAT = 12'h008;
  localparam int TX_POLL_BIT  = 24;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_FAULT_BIT = 1;
endpackage : spimc_pkg

// *** spimc_properties.sv ***
`timescale 1ns/100ps
module spimc_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  // ****************************************************
  // clock rise count per frame
  // ****************************************************
  logic [5:0] rises;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rises <= 6'h00;
    else if (chip_select_n) rises <= 6'h00;
    else if ($rose(sclk)) rises <= rises + 6'h01;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sel_fall_s;
    $fell(chip_select_n);
  endsequence

  sequence sel_rise_s;
    $rose(chip_select_n);
  endsequence

  // ****************************************************
  // link properties
  // ****************************************************
  idle_clock_a: assert property (chip_select_n |-> !sclk)
    else $error("serial clock high outside frame");
  clock_frame_a: assert property ($rose(sclk) |->
    !chip_select_n && !$past(chip_select_n, 3))
    else $error("serial clock rose without lead time");
  frame_count_a: assert property (sel_rise_s |->
    rises == 6'h00 || rises == 6'h18)
    else $error("frame clock count not 0 or 24");
  oe_drive_a: assert property (sel_fall_s |-> ##[1:3] !miso_oe_n)
    else $error("output not driven after select fall");
  oe_release_a: assert property (chip_select_n [*5] |-> miso_oe_n)
    else $error("output driven while select high");
  frame_end_a: assert property (sel_rise_s |-> ##[1:4] miso_oe_n)
    else $error("output still driven after frame end");
  miso_shift_a: assert property ($changed(miso) && !miso_oe_n &&
    $past(!miso_oe_n) |-> !sclk && !$past(sclk))
    else $error("output bit changed outside clock low");
  mosi_hold_a: assert property (sclk && $past(sclk) |->
    $stable(mosi))
    else $error("input data moved while clock high");
endmodule : spimc_properties
